//--- verilog/pdm_ctrl.sv
// Purpose: Paged bus DRAM controller with autonomous refresh
// Assumes: Bus clock PHI2 and bus lines are synchronous to SYS_CLK
// Notes:   One memory cycle per bus clock period, no wait states
`timescale 1ns/100ps
module pdm_ctrl #(
  parameter bit ROW_HAS_A6 = 1'b1,  // 1: A6 in row, A12/A13 in column
  parameter int CNT_W      = 6      // Phase counter width
) (
  input  wire logic                                     SYS_CLK,
  input  wire logic                                     RST,
  // Wishbone classic slave
  input  wire logic                                     CYC_I,
  input  wire logic                                     STB_I,
  input  wire logic                                     WE_I,
  input  wire logic [7:0]                               ADR_I,
  input  wire logic [3:0]                               SEL_I,
  input  wire logic [31:0]                              DAT_I,
  output logic      [31:0]                              DAT_O,
  output logic                                          ACK_O,
  // Bus side
  input  wire logic                                     PHI2,
  input  wire logic [15:0]                              ADDR,
  input  wire logic [pdm_pkg::DATA_W-1:0]               DO,
  input  wire logic                                     SMEMR,
  input  wire logic                                     MWRT,
  input  wire logic                                     PDBIN,
  input  wire logic                                     EXTENDED_HIT_N,
  input  wire logic                                     BUS_SIDE_SELECT_N,
  output logic      [pdm_pkg::DATA_W-1:0]               DI_OUT,
  output logic                                          DI_OE,
  output logic                                          BOARD_HIT_N,
  // Memory array side
  output logic      [pdm_pkg::NUM_PAGES-1:0]            RAS_N,
  output logic                                          CAS_N,
  output logic                                          WE_N,
  output logic      [pdm_pkg::MA_W-1:0]                 MA,
  output logic      [pdm_pkg::DATA_W-1:0]               MEM_DIN,
  input  wire logic [pdm_pkg::NUM_PAGES*pdm_pkg::DATA_W-1:0] MEM_DOUT
);
  import pdm_pkg::*;

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (DOC_CYC >= (1 << CNT_W) - 1) begin : g_bad_cnt
    $error("Phase counter too narrow for cycle timing");
  end
  if (!(RAS_CYC < COL_CYC && COL_CYC < CAS_CYC && CAS_CYC < DOC_CYC)) begin : g_bad_order
    $error("Strobe timing out of order");
  end

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [31:0]          ctrl_q;        // Page settings and refresh enable
  logic                 ack_q;         // Bus acknowledge
  logic [31:0]          dat_q;         // Bus read data
  logic                 phi2_q;        // Previous bus clock level
  logic                 cyc_start;     // Bus clock falling edge
  pdm_state_t           state_q;       // Strobe sequencer
  logic [CNT_W-1:0]     cnt_q;         // Cycles since cycle start
  pdm_kind_t            kind_q;        // Current cycle kind
  pdm_kind_t            kind_d;        // Kind chosen at cycle start
  logic [NUM_PAGES-1:0] page_q;        // Page latched at cycle start
  logic [NUM_PAGES-1:0] page_sel;      // Page chosen from address
  logic [1:0]           blk_ofs;       // Block inside the page
  logic                 hit_n;         // No page matches
  logic [MA_W-1:0]      row_q;         // Latched row group
  logic [MA_W-1:0]      col_q;         // Latched column group
  logic [MA_W-1:0]      row_d;         // Row group from bus address
  logic [MA_W-1:0]      col_d;         // Column group from bus address
  logic [MA_W-1:0]      ref_row_q;     // Refresh row counter
  logic [DATA_W-1:0]    wdata_q;       // Write data register
  logic [DATA_W-1:0]    rdata_q;       // Output data register
  logic [NUM_PAGES-1:0] ras_n_q;       // Row strobes
  logic                 cas_n_q;       // Column strobe
  logic                 we_n_q;        // Write enable
  logic [MA_W-1:0]      ma_q;          // Memory address pins
  logic                 row_address_phase_q; // Row address phase
  logic                 drive_en_n;    // Read drive enable, active low

  // ************************************************************
  // Page selection
  // ************************************************************
  pdm_page_sel #(
    .PAGES       (NUM_PAGES)
  ) u_page_sel (
    .addr_hi     (ADDR[15:12]),
    .sw          (ctrl_q[CTRL_SW0_LSB +: NUM_PAGES*SW_W]),
    .page_sel    (page_sel),
    .blk_ofs     (blk_ofs),
    .board_hit_n (hit_n)
  );

  // ************************************************************
  // Wishbone register slave
  // ************************************************************
  // Single-cycle acknowledge, dropped the cycle after it is given
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= CYC_I & STB_I & ~ack_q;
    end
  end
  // Control register, byte lanes honoured
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ctrl_q <= CTRL_RESET;
    end else if (CYC_I && STB_I && !ack_q && WE_I && ADR_I == REG_CTRL) begin
      for (int b = 0; b < 4; b++) begin
        if (SEL_I[b]) begin
          ctrl_q[b*8 +: 8] <= DAT_I[b*8 +: 8];
        end
      end
    end
  end
  // Read mux; unmapped offsets answer zero
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      dat_q <= 32'h0000_0000;
    end else if (CYC_I && STB_I && !ack_q) begin
      dat_q <= 32'h0000_0000;
      if (ADR_I == REG_CTRL) begin
        dat_q <= ctrl_q & 32'h0001_0FFF;
      end else if (ADR_I == REG_STATUS) begin
        dat_q[STAT_ROW_LSB +: MA_W]      <= ref_row_q;
        dat_q[STAT_PAGE_LSB +: NUM_PAGES] <= page_q;
        dat_q[STAT_KIND_LSB +: 2]         <= kind_q;
      end
    end
  end
  assign ACK_O = ack_q;
  assign DAT_O = dat_q;

  // ************************************************************
  // Cycle start and kind
  // ************************************************************
  // bus clock fall
  assign cyc_start = phi2_q & ~PHI2;
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      phi2_q <= 1'b0;
    end else begin
      phi2_q <= PHI2;
    end
  end
  // Access wins; an idle bus cycle becomes a refresh cycle
  always_comb begin
    kind_d = KIND_NULL;
    if (!hit_n && SMEMR) begin
      kind_d = KIND_READ;
    end else if (!hit_n && MWRT) begin
      kind_d = KIND_WRITE;
    end else if (ctrl_q[CTRL_REFEN]) begin
      kind_d = KIND_REFR;
    end
  end

  // ************************************************************
  // Address groups
  // ************************************************************
  // build-time A6/A12/A13 routing
  always_comb begin
    if (ROW_HAS_A6) begin
      row_d = {ADDR[6], ADDR[5:0]};
      col_d = {blk_ofs, ADDR[11:7]};
    end else begin
      row_d = {blk_ofs[0], ADDR[5:0]};
      col_d = {blk_ofs[1], ADDR[6], ADDR[11:7]};
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      row_q   <= '0;
      col_q   <= '0;
      wdata_q <= '0;
      page_q  <= '0;
      kind_q  <= KIND_NULL;
    end else if (cyc_start) begin
      row_q   <= row_d;
      col_q   <= col_d;
      wdata_q <= DO;
      page_q  <= page_sel;
      kind_q  <= kind_d;
    end
  end

  // ************************************************************
  // Strobe sequencer
  // ************************************************************
  // Phase counter restarts at every bus clock fall
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      cnt_q <= '0;
    end else if (cyc_start) begin
      cnt_q <= '0;
    end else if (cnt_q != '1) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
  // A short bus period restarts the sequence mid-way by design
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state_q <= ST_IDLE;
    end else if (cyc_start) begin
      state_q <= ST_ROW;
    end else begin
      unique case (state_q)
        ST_IDLE: state_q <= ST_IDLE;
        ST_ROW:  if (cnt_q == CNT_W'(RAS_CYC - 1)) state_q <= ST_RAS;
        ST_RAS:  if (cnt_q == CNT_W'(COL_CYC - 1)) state_q <= ST_COL;
        ST_COL:  if (cnt_q == CNT_W'(CAS_CYC - 1)) state_q <= ST_CAS;
        ST_CAS:  if (cnt_q == CNT_W'(DOC_CYC - 1)) state_q <= ST_DONE;
        ST_DONE: state_q <= ST_DONE;
      endcase
    end
  end
  // Row address phase: high from the start of each cycle until row strobe
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      row_address_phase_q <= 1'b0;
    end else begin
      row_address_phase_q <= cyc_start | (row_address_phase_q & (cnt_q != CNT_W'(RAS_CYC - 1)));
    end
  end
  // Row strobes; refresh strobes every page, access only one
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ras_n_q <= '1;
    end else if (cyc_start) begin
      ras_n_q <= '1;
    end else if (state_q == ST_ROW && cnt_q == CNT_W'(RAS_CYC - 1)) begin
      if (kind_q == KIND_REFR) begin
        ras_n_q <= '0;
      end else if (kind_q != KIND_NULL) begin
        ras_n_q <= ~page_q;
      end
    end else if (state_q == ST_CAS && cnt_q == CNT_W'(DOC_CYC - 1)) begin
      ras_n_q <= '1;
    end
  end
  // Column strobe to all chips; held until next bus clock fall
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      cas_n_q <= 1'b1;
    end else if (cyc_start) begin
      cas_n_q <= 1'b1;
    end else if (state_q == ST_COL && cnt_q == CNT_W'(CAS_CYC - 1)) begin
      cas_n_q <= ~(kind_q == KIND_READ || kind_q == KIND_WRITE);
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      we_n_q <= 1'b1;
    end else if (cyc_start) begin
      we_n_q <= 1'b1;
    end else if (state_q == ST_RAS && cnt_q == CNT_W'(COL_CYC - 1)) begin
      we_n_q <= (kind_q != KIND_WRITE);
    end else if (state_q == ST_CAS && cnt_q == CNT_W'(DOC_CYC - 1)) begin
      we_n_q <= 1'b1;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ma_q <= '0;
    end else if (cyc_start) begin
      ma_q <= (kind_d == KIND_REFR) ? ref_row_q : row_d;
    end else if (state_q == ST_RAS && cnt_q == CNT_W'(COL_CYC - 1) && kind_q != KIND_REFR) begin
      ma_q <= col_q;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ref_row_q <= '0;
    end else if (state_q == ST_CAS && cnt_q == CNT_W'(DOC_CYC - 1) && kind_q == KIND_REFR) begin
      ref_row_q <= ref_row_q + 1'b1;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rdata_q <= '0;
    end else if (state_q == ST_CAS && cnt_q == CNT_W'(DOC_CYC - 1)) begin
      for (int p = 0; p < NUM_PAGES; p++) begin
        if (page_q[p]) begin
          rdata_q <= MEM_DOUT[p*DATA_W +: DATA_W];
        end
      end
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // all selects low, read strobes high
  assign drive_en_n = ~(~hit_n & ~EXTENDED_HIT_N & ~BUS_SIDE_SELECT_N & SMEMR & PDBIN);
  assign DI_OE       = ~drive_en_n;
  assign DI_OUT      = rdata_q;
  assign BOARD_HIT_N = hit_n;
  assign RAS_N       = ras_n_q;
  assign CAS_N       = cas_n_q;
  assign WE_N        = we_n_q;
  assign MA          = ma_q;
  // one byte shared by three pages
  assign MEM_DIN     = wdata_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  chk_ras_one_page: assert property ((kind_q != KIND_REFR) |-> $onehot0(~RAS_N))
    else $error("Row strobe on more than one page");
  chk_row_at_ras: assert property ((RAS_N != '1 && $past(RAS_N) == '1 && kind_q != KIND_REFR)
    |-> MA == row_q)
    else $error("Row address not on pins at row strobe");
  chk_cas_in_ras: assert property ($fell(CAS_N) |-> (RAS_N != '1) && MA == col_q)
    else $error("Column strobe without row strobe or column address");
  chk_we_before_cas: assert property (($fell(CAS_N) && kind_q == KIND_WRITE) |-> $past(!WE_N))
    else $error("Write enable not settled before column strobe");
  chk_wdata_latch: assert property (cyc_start |=> MEM_DIN == $past(DO))
    else $error("Write data not latched at cycle start");
  chk_drive_gate: assert property (DI_OE |-> (SMEMR && PDBIN && !BOARD_HIT_N
    && !EXTENDED_HIT_N && !BUS_SIDE_SELECT_N))
    else $error("Bus data driven without full selection");
  chk_refresh_step: assert property ((state_q == ST_CAS && cnt_q == CNT_W'(DOC_CYC - 1)
    && kind_q == KIND_REFR) |=> ref_row_q == MA_W'($past(ref_row_q) + 1'b1))
    else $error("Refresh row did not advance");
  chk_cycle_start: assert property (cyc_start |=> state_q == ST_ROW ##1 row_address_phase_q)
    else $error("Cycle did not start at bus clock fall");
  chk_rd_capture: assert property ((state_q == ST_CAS && cnt_q == CNT_W'(DOC_CYC - 1) && kind_q == KIND_READ)
    |=> RAS_N == '1 && DI_OUT == $past(MEM_DOUT[(page_q[2] ? 2 : page_q[1] ? 1 : 0)*DATA_W +: DATA_W]))
    else $error("Read byte not captured at end of row strobe");
  cov_read: cover property (cyc_start && kind_d == KIND_READ ##[1:40] !CAS_N);
  cov_write: cover property (cyc_start && kind_d == KIND_WRITE ##[1:40] !WE_N);
  cov_refresh: cover property (cyc_start && kind_d == KIND_REFR ##[1:40] RAS_N == '0);

endmodule

//--- verilog/pdm_pkg.sv
// Purpose: Shared constants for the paged bus DRAM controller
// Assumes: 50 MHz system clock, bus clock sampled as a plain input
// Notes:   Timing figures are in ns; cycle counts are derived here
package pdm_pkg;

  // ************************************************************
  // Clock and cycle timing
  // ************************************************************
  localparam int SYS_CLK_NS  = 20;   // System clock period
  localparam int T_RAS_NS    = 40;   // Cycle start to row strobe
  localparam int T_COL_NS    = 80;   // Cycle start to column mux
  localparam int T_CAS_NS    = 120;  // Cycle start to column strobe
  localparam int T_DOC_NS    = 380;  // Cycle start to read capture
  // Least times round up to whole clock cycles
  localparam int RAS_CYC = (T_RAS_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int COL_CYC = (T_COL_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int CAS_CYC = (T_CAS_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int DOC_CYC = (T_DOC_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

  // ************************************************************
  // Memory geometry
  // ************************************************************
  localparam int NUM_PAGES  = 3;     // Pages of eight chips
  localparam int MA_W       = 7;     // Shared memory address pins
  localparam int DATA_W     = 8;     // Byte wide bus
  localparam int SW_W       = 4;     // Switch setting width

  // ************************************************************
  // Register map (byte addresses) and fields
  // ************************************************************
  localparam logic [7:0] REG_CTRL   = 8'h00;  // Page starts, refresh enable
  localparam logic [7:0] REG_STATUS = 8'h04;  // Refresh row, last page
  localparam int CTRL_SW0_LSB  = 0;           // Page 0 start setting
  localparam int CTRL_SW1_LSB  = 4;           // Page 1 start setting
  localparam int CTRL_SW2_LSB  = 8;           // Page 2 start setting
  localparam int CTRL_REFEN    = 16;          // Refresh enable bit
  localparam int STAT_ROW_LSB  = 0;           // Refresh row counter
  localparam int STAT_PAGE_LSB = 8;           // Page of last cycle, one-hot or zero
  localparam int STAT_KIND_LSB = 12;          // Last cycle kind
  localparam logic [31:0] CTRL_RESET = 32'h0001_0840;  // 0000/4000/8000

  // ************************************************************
  // Cycle kinds and sequencer states
  // ************************************************************
  typedef enum logic [1:0] {
    KIND_NULL  = 2'h0,
    KIND_READ  = 2'h1,
    KIND_WRITE = 2'h2,
    KIND_REFR  = 2'h3
  } pdm_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ROW  = 3'h1,
    ST_RAS  = 3'h3,
    ST_COL  = 3'h2,
    ST_CAS  = 3'h6,
    ST_DONE = 3'h7
  } pdm_state_t;

endpackage

//--- verilog/pdm_page_sel.sv
// Purpose: Page match and priority from the top address nibble
// Assumes: Settings are stable during a bus cycle
// Notes:   Pages wrap past FFFF into low memory
`timescale 1ns/100ps
module pdm_page_sel #(
  parameter int PAGES = pdm_pkg::NUM_PAGES
) (
  input  wire logic [3:0]         addr_hi,     // Bus A15..A12
  input  wire logic [PAGES*4-1:0] sw,          // Start settings
  output logic      [PAGES-1:0]   page_sel,    // One-hot or zero
  output logic      [1:0]         blk_ofs,     // 4K block inside page
  output logic                    board_hit_n  // Low if any page hits
);
  import pdm_pkg::*;

  logic [PAGES-1:0] match;             // Raw per-page match
  logic [1:0]       ofs [PAGES];       // Per-page block offset

  // ************************************************************
  // Per-page comparison
  // ************************************************************
  // nibble against setting
  for (genvar p = 0; p < PAGES; p++) begin : g_cmp
    logic [3:0] diff;
    assign diff     = addr_hi - sw[p*4 +: 4];
    assign match[p] = (diff[3:2] == 2'h0);
    assign ofs[p]   = diff[1:0];
  end

  // Lowest numbered matching page wins
  always_comb begin
    page_sel = '0;
    blk_ofs  = 2'h0;
    for (int p = PAGES - 1; p >= 0; p--) begin
      if (match[p]) begin
        page_sel    = '0;
        page_sel[p] = 1'b1;
        blk_ofs     = ofs[p];
      end
    end
  end

  assign board_hit_n = ~|match;

endmodule

//--- bench/pdm_bus_mst.sv
// Purpose: Bus master model for the bus side of the controller
// Assumes: Bench commands are sampled once a bus period
// Notes:   Bus clock runs free, 32 system clocks a period
`timescale 1ns/100ps
module pdm_bus_mst (
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic [15:0] cmd_addr,  // Address to present
  input  wire logic [7:0]  cmd_do,    // Byte to write
  input  wire logic        cmd_rd,    // Memory read wanted
  input  wire logic        cmd_wr,    // Memory write wanted
  output logic             phi2,
  output logic [15:0]      addr,
  output logic [7:0]       dout,
  output logic             smemr,
  output logic             mwrt,
  output logic             pdbin
);
  logic [4:0]  cnt_q;  // Place in bus period
  logic [15:0] a_q;    // Held address
  logic [7:0]  d_q;    // Held write byte
  logic        rd_q;   // Held read status
  logic        wr_q;   // Held write status
  // bus period
  // Long period leaves room for the whole memory cycle
  always_ff @(posedge SYS_CLK) begin
    cnt_q <= RST ? 5'h00 : cnt_q + 5'h01;
  end
  assign phi2 = (cnt_q < 5'h08);
  // Command taken at bus clock rise, held all period
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end else if (cnt_q == 5'h00) begin
      a_q  <= cmd_addr;
      d_q  <= cmd_do;
      rd_q <= cmd_rd;
      wr_q <= cmd_wr;
    end
  end
  assign smemr = rd_q;
  assign pdbin = rd_q;
  assign mwrt  = wr_q;
  // Idle lines show the inverse, never a stale value
  assign addr = (rd_q | wr_q) ? a_q : ~a_q;
  assign dout = wr_q ? d_q : ~d_q;
endmodule

//--- bench/test_paged_dram_bus_memory_ctrl.sv
// Purpose: Self-checking bench for the paged DRAM controller
// Assumes: Default build, A6 routed to the row group
// Notes:   Chip outputs are fixed bytes, one per page
`timescale 1ns/100ps
module test_paged_dram_bus_memory_ctrl;
  import pdm_pkg::*;
  logic        clk, rst, cyc, stb, we, ack, ext_n, bss_n, c_rd, c_wr;
  logic        phi2, smemr, mwrt, pdbin, di_oe, hit_n, cas_n, we_n;
  logic [7:0]  adr, c_do, dout, di, mdin;
  logic [3:0]  sel;
  logic [31:0] dat_w, dat_r, q, s0;
  logic [15:0] addr, c_addr;
  logic [2:0]  ras_n;
  logic [6:0]  ma;
  logic [23:0] mdout;
  int          error_cnt, num_checks, cyc_cnt;
  pdm_ctrl dut_u (.SYS_CLK(clk), .RST(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack), .PHI2(phi2),
    .ADDR(addr), .DO(dout), .SMEMR(smemr), .MWRT(mwrt), .PDBIN(pdbin),
    .EXTENDED_HIT_N(ext_n), .BUS_SIDE_SELECT_N(bss_n), .DI_OUT(di), .DI_OE(di_oe),
    .BOARD_HIT_N(hit_n), .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .MA(ma),
    .MEM_DIN(mdin), .MEM_DOUT(mdout));
  pdm_bus_mst mst_u (.SYS_CLK(clk), .RST(rst), .cmd_addr(c_addr), .cmd_do(c_do),
    .cmd_rd(c_rd), .cmd_wr(c_wr), .phi2(phi2), .addr(addr), .dout(dout),
    .smemr(smemr), .mwrt(mwrt), .pdbin(pdbin));
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Classic single cycle; ack and read data taken at one rising edge
  // Waits for ack as long as it takes; only the run timeout ends a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; dat_w <= d;
    do @(posedge clk); while (ack !== 1'b1);
    r = dat_r;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  // One memory cycle, judged at each strobe; parks on a read after
  task automatic mem_cyc(input logic [15:0] a, input logic [7:0] d, input logic r,
    input logic w, input logic [2:0] eras, input logic [6:0] erow, input logic [6:0] ecol,
    input logic [7:0] edi);
    int n;
    @(posedge clk);
    c_addr <= a; c_do <= d; c_rd <= r; c_wr <= w;
    for (n = 0; n < 40 && phi2 !== 1'b0; n++) @(negedge clk);
    for (n = 0; n < 40 && phi2 !== 1'b1; n++) @(negedge clk);
    for (n = 0; n < 40 && ras_n === 3'h7; n++) @(negedge clk);
    check(ras_n, eras, "row strobe pages");
    check(ma, erow, "row address");
    if (r | w) begin
      check(hit_n, 1'b0, "board hit");
      for (n = 0; n < 40 && cas_n !== 1'b0; n++) @(negedge clk);
      check(ma, ecol, "column address");
      check(we_n, !w, "write enable at column strobe");
      if (w) check(mdin, d, "write byte to chips");
    end
    for (n = 0; n < 40 && ras_n !== 3'h7; n++) @(negedge clk);
    if (r) check(di, edi, "read byte captured");
    if (!(r | w)) check(cas_n, 1'b1, "no column strobe in refresh");
    check(di_oe, r, "data drive enable");
    @(posedge clk);
    c_addr <= 16'h0000; c_rd <= 1'b1; c_wr <= 1'b0;
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    check({ras_n, cas_n, we_n}, 5'h1F, "strobes idle");
    wb(1'b0, REG_CTRL, 4'hF, 32'h0, q);
    check(q, CTRL_RESET, "control reset");
    wb(1'b0, 8'h08, 4'hF, 32'h0, q);
    check(q, 32'h0, "unmapped read");
  endtask
  task automatic t_read();
    mem_cyc(16'h5ABC, 8'h00, 1'b1, 1'b0, 3'h5, 7'h3C, 7'h35, 8'h5A);
    @(posedge clk) ext_n <= 1'b1;
    @(negedge clk) check(di_oe, 1'b0, "extended select off");
    @(posedge clk) begin ext_n <= 1'b0; bss_n <= 1'b1; end
    @(negedge clk) check(di_oe, 1'b0, "bus side select off");
    @(posedge clk) bss_n <= 1'b0;
  endtask
  task automatic t_write();
    mem_cyc(16'h2F81, 8'h96, 1'b0, 1'b1, 3'h6, 7'h01, 7'h5F, 8'h00);
  endtask
  task automatic t_prio();
    wb(1'b1, REG_CTRL, 4'h1, 32'hFFFF_FF44, q);
    wb(1'b0, REG_CTRL, 4'hF, 32'h0, q);
    check(q, 32'h0001_0844, "lane write");
    mem_cyc(16'h5ABC, 8'h00, 1'b1, 1'b0, 3'h6, 7'h3C, 7'h35, 8'hA5);
  endtask
  task automatic t_wrap();
    wb(1'b1, REG_CTRL, 4'h3, 32'h0000_0D44, q);
    mem_cyc(16'h0123, 8'h00, 1'b1, 1'b0, 3'h3, 7'h23, 7'h62, 8'hC3);
  endtask
  task automatic t_refresh();
    wb(1'b0, REG_STATUS, 4'hF, 32'h0, s0);
    mem_cyc(16'h0000, 8'h00, 1'b0, 1'b0, 3'h0, s0[6:0], 7'h00, 8'h00);
    wb(1'b0, REG_STATUS, 4'hF, 32'h0, q);
    check(q[6:0], 7'(s0[6:0] + 7'h01), "refresh row advance");
    check(q[13:12], KIND_REFR, "refresh kind");
  endtask
  // Unmapped address with refresh off: a whole period with no strobe
  task automatic t_null();
    int n;
    wb(1'b1, REG_CTRL, 4'h4, 32'h0000_0000, q);
    @(posedge clk);
    c_addr <= 16'h9000; c_rd <= 1'b1; c_wr <= 1'b0;
    for (n = 0; n < 40 && phi2 !== 1'b0; n++) @(negedge clk);
    for (n = 0; n < 40 && phi2 !== 1'b1; n++) @(negedge clk);
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      if (ras_n !== 3'h7 || di_oe !== 1'b0) break;
    end
    check({ras_n, di_oe, hit_n}, 5'h1D, "no page selected, no strobe");
  endtask
  // ************************************************************
  // Clock, timeout and main sequence
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t run timed out", $time);
      results();
    end
  end
  initial begin
    rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0; dat_w = 32'h0;
    ext_n = 1'b0; bss_n = 1'b0; c_addr = 16'h0; c_do = 8'h00; c_rd = 1'b0; c_wr = 1'b0;
    mdout = 24'hC3_5A_A5; error_cnt = 0; num_checks = 0; cyc_cnt = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_reset();
    t_read();
    t_write();
    t_prio();
    t_wrap();
    t_refresh();
    t_null();
    results();
  end
endmodule
